/* File: hw/ddspr_regs.sv */
// serial-port register bank, sweep timing and accumulators of the dds core
`timescale 1ns/1ns
`default_nettype none
module ddspr_regs (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic        i_sclk,
  input  wire logic        i_csb_n,
  input  wire logic        i_sdio,
  output logic             o_sdio,
  output logic             o_sdio_oe,
  input  wire logic        i_io_update,
  input  wire logic        i_pll_unlock,
  input  wire logic        i_sync_in_mode,
  input  wire logic        i_profile_sel,
  input  wire logic        i_sweep_active,
  input  wire logic [7:0]  i_sweep_ramp_rate,
  input  wire logic [47:0] i_sweep_delta,
  input  wire logic [47:0] i_tuning_word_zero,
  output logic             o_sync_tick,
  output logic [47:0]      o_freq_word,
  output logic [13:0]      o_phase_word,
  output logic             o_unlock
);
  typedef enum logic [1:0] {ST_INSTR = 2'b01, ST_DATA = 2'b10} ddspr_state_t;

  // serial port state
  ddspr_state_t st_q, st_d;
  logic        sclk_q;
  logic [6:0]  cnt_q, cnt_d, width;
  logic [7:0]  ins_q, ins_d, ins_full;
  logic        rd_q, rd_d;
  logic [4:0]  addr_q, addr_d;
  logic [63:0] sh_q, sh_d, rsh_q, rsh_d, wval;
  logic        oe_q, oe_d, so_q, so_d, rdclr;
  logic [63:0] p6b_q, p6b_d, p7b_q, p7b_d;
  logic [31:0] cfb_q, cfb_d;
  logic        lsb1st;
  logic        rise, fall;

  function automatic logic [6:0] width_of(input logic [4:0] a);
    unique case (a)
      ddspr_pkg::ADDR_PROF_SIX, ddspr_pkg::ADDR_PROF_SEVEN: width_of = ddspr_pkg::PROF_BITS;
      ddspr_pkg::ADDR_CTRL_ONE: width_of = ddspr_pkg::CTRL_BITS;
      default: width_of = 7'h00;
    endcase
  endfunction : width_of

  // active registers and core state
  logic [63:0] p6_q, p6_d, p7_q, p7_d;
  logic [31:0] cf_q, cf_d;
  logic        unl_q, unl_d;
  logic [1:0]  div_q, div_d;
  logic        tick;
  logic        fpend_q, fpend_d, ppend_q, ppend_d;
  logic [7:0]  ramp_q, ramp_d;
  logic [47:0] facc_q, facc_d, pacc_q, pacc_d, ftw_now;
  logic [63:0] prof;
  logic [47:0] fw_d;
  logic [13:0] pw_d;

  assign lsb1st = cf_q[ddspr_pkg::BIT_LSB_FIRST];
  assign rise   = i_sclk & ~sclk_q & ~i_csb_n;
  assign fall   = ~i_sclk & sclk_q & ~i_csb_n;
  assign width  = width_of(addr_q);
  assign tick   = (div_q == ddspr_pkg::SYNC_DIV_LAST);

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    ins_d    = ins_q;
    rd_d     = rd_q;
    addr_d   = addr_q;
    sh_d     = sh_q;
    rsh_d    = rsh_q;
    oe_d     = oe_q;
    so_d     = so_q;
    p6b_d    = p6b_q;
    p7b_d    = p7b_q;
    cfb_d    = cfb_q;
    rdclr    = 1'b0;
    ins_full = lsb1st ? {i_sdio, ins_q[7:1]} : {ins_q[6:0], i_sdio};
    wval     = 64'h0;
    if (i_csb_n) begin
      st_d  = ST_INSTR;
      cnt_d = 7'h00;
      oe_d  = 1'b0;
    end else if (rise) begin
      unique case (st_q)
        ST_INSTR: begin
          oe_d  = 1'b0;
          ins_d = ins_full;
          cnt_d = cnt_q + 7'h01;
          if (cnt_q == 7'(ddspr_pkg::INSTR_BITS - 1)) begin
            st_d   = ST_DATA;
            cnt_d  = 7'h00;
            rd_d   = ins_full[ddspr_pkg::INSTR_READ_BIT];
            addr_d = ins_full[4:0];
            unique case (ins_full[4:0])
              ddspr_pkg::ADDR_PROF_SIX:   rsh_d = p6b_q;
              ddspr_pkg::ADDR_PROF_SEVEN: rsh_d = p7b_q;
              ddspr_pkg::ADDR_CTRL_ONE:   rsh_d = {32'h0, cfb_q[31:25], unl_q, cfb_q[23:0]};
              default:                    rsh_d = 64'h0;
            endcase
            rdclr = ins_full[ddspr_pkg::INSTR_READ_BIT]
                    && (ins_full[4:0] == ddspr_pkg::ADDR_CTRL_ONE);
          end
        end
        ST_DATA: begin
          sh_d  = lsb1st ? {i_sdio, sh_q[63:1]} : {sh_q[62:0], i_sdio};
          cnt_d = cnt_q + 7'h01;
          wval  = lsb1st ? (sh_d >> (ddspr_pkg::PROF_BITS - width)) : sh_d;
          if ((cnt_q + 7'h01 == width) || (width == 7'h00)) begin
            st_d  = ST_INSTR;
            cnt_d = 7'h00;
            if (!rd_q) begin
              unique case (addr_q)
                ddspr_pkg::ADDR_PROF_SIX:   p6b_d = wval & ddspr_pkg::PROF_MASK;
                ddspr_pkg::ADDR_PROF_SEVEN: p7b_d = wval & ddspr_pkg::PROF_MASK;
                ddspr_pkg::ADDR_CTRL_ONE:   cfb_d = wval[31:0] & ddspr_pkg::CTRL_MASK;
                default:                    cfb_d = cfb_q;
              endcase
            end
          end
        end
        default: st_d = ST_INSTR;
      endcase
    end else if (fall && st_q == ST_DATA && rd_q && width != 7'h00) begin
      oe_d = 1'b1;
      so_d = lsb1st ? rsh_q[6'(cnt_q)] : rsh_q[6'(width - 7'h01 - cnt_q)];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q   <= ST_INSTR;
      sclk_q <= 1'b0;
      cnt_q  <= 7'h00;
      ins_q  <= 8'h00;
      rd_q   <= 1'b0;
      addr_q <= 5'h00;
      sh_q   <= 64'h0;
      rsh_q  <= 64'h0;
      oe_q   <= 1'b0;
      so_q   <= 1'b0;
      p6b_q  <= ddspr_pkg::PROF_RESET;
      p7b_q  <= ddspr_pkg::PROF_RESET;
      cfb_q  <= ddspr_pkg::CTRL_RESET;
    end else if (i_ce) begin
      st_q   <= st_d;
      sclk_q <= i_sclk;
      cnt_q  <= cnt_d;
      ins_q  <= ins_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
      sh_q   <= sh_d;
      rsh_q  <= rsh_d;
      oe_q   <= oe_d;
      so_q   <= so_d;
      p6b_q  <= p6b_d;
      p7b_q  <= p7b_d;
      cfb_q  <= cfb_d;
    end
  end

  // core: update copy, sync divider, sweep counter, accumulators
  assign prof    = i_profile_sel ? p7_q : p6_q;
  assign ftw_now = (i_sweep_active ? i_tuning_word_zero : prof[ddspr_pkg::FTW_MSB:0])
                   + facc_q;

  always_comb begin
    p6_d    = p6_q;
    p7_d    = p7_q;
    cf_d    = cf_q;
    if (i_io_update) begin
      p6_d = p6b_q;
      p7_d = p7b_q;
      cf_d = cfb_q;
    end
    unl_d   = (unl_q && !rdclr) || (i_pll_unlock && i_sync_in_mode);
    div_d   = div_q + 2'h1;
    fpend_d = (i_io_update && cfb_q[ddspr_pkg::BIT_FREQ_AUTOCLR]) || (fpend_q && !tick);
    ppend_d = (i_io_update && cfb_q[ddspr_pkg::BIT_PH_AUTOCLR]) || (ppend_q && !tick);
    ramp_d  = ramp_q;
    facc_d  = facc_q;
    pacc_d  = pacc_q;
    if (tick) begin
      if (i_sweep_active) begin
        if (ramp_q == 8'h00) begin
          ramp_d = i_sweep_ramp_rate;
          facc_d = facc_q + i_sweep_delta;
        end else begin
          ramp_d = ramp_q - 8'h01;
        end
      end
      pacc_d = pacc_q + ftw_now;
      if (fpend_q) facc_d = 48'h0;
      if (ppend_q) pacc_d = 48'h0;
    end
    if (i_io_update && cfb_q[ddspr_pkg::BIT_RAMP_RELOAD] && i_sweep_active) begin
      ramp_d = i_sweep_ramp_rate;
    end
    if (cf_q[ddspr_pkg::BIT_FREQ_CLR]) facc_d = 48'h0;
    if (cf_q[ddspr_pkg::BIT_PH_CLR]) pacc_d = 48'h0;
    fw_d = ftw_now;
    pw_d = pacc_q[47:34] + prof[ddspr_pkg::POW_MSB:ddspr_pkg::POW_LSB]
           + (cf_q[ddspr_pkg::BIT_SINE] ? 14'h0000 : ddspr_pkg::COS_QUARTER_TURN);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      p6_q        <= ddspr_pkg::PROF_RESET;
      p7_q        <= ddspr_pkg::PROF_RESET;
      cf_q        <= ddspr_pkg::CTRL_RESET;
      unl_q       <= 1'b0;
      div_q       <= 2'h0;
      fpend_q     <= 1'b0;
      ppend_q     <= 1'b0;
      ramp_q      <= 8'h00;
      facc_q      <= 48'h0;
      pacc_q      <= 48'h0;
      o_sync_tick <= 1'b0;
      o_freq_word <= 48'h0;
      o_phase_word <= 14'h0;
    end else if (i_ce) begin
      p6_q        <= p6_d;
      p7_q        <= p7_d;
      cf_q        <= cf_d;
      unl_q       <= unl_d;
      div_q       <= div_d;
      fpend_q     <= fpend_d;
      ppend_q     <= ppend_d;
      ramp_q      <= ramp_d;
      facc_q      <= facc_d;
      pacc_q      <= pacc_d;
      o_sync_tick <= tick;
      o_freq_word <= fw_d;
      o_phase_word <= pw_d;
    end
  end

  assign o_sdio    = so_q;
  assign o_sdio_oe = oe_q;
  assign o_unlock  = unl_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst || !i_ce);

  sequence s_ph_clr_req;
    i_io_update && cfb_q[ddspr_pkg::BIT_PH_AUTOCLR];
  endsequence
  sequence s_ph_clr_done;
    ##[0:3] (tick && ppend_q) ##1 (pacc_q == 48'h0);
  endsequence
  sequence s_f_clr_req;
    i_io_update && cfb_q[ddspr_pkg::BIT_FREQ_AUTOCLR];
  endsequence
  sequence s_f_clr_done;
    ##[0:3] (tick && fpend_q) ##1 (facc_q == 48'h0);
  endsequence

  property p_unlock_set;
    (i_pll_unlock && i_sync_in_mode) |=> unl_q;
  endproperty
  a_unlock_set: assert property (p_unlock_set) else $error("unlock flag missed");
  property p_unlock_sticky;
    (unl_q && !rdclr) |=> unl_q;
  endproperty
  a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock flag lost");
  property p_unlock_clear;
    (rdclr && !(i_pll_unlock && i_sync_in_mode)) |=> !unl_q;
  endproperty
  a_unlock_clear: assert property (p_unlock_clear) else $error("readback kept flag");
  property p_sync_div;
    tick |=> !tick [*3] ##1 tick;
  endproperty
  a_sync_div: assert property (p_sync_div) else $error("sync clock not quarter rate");
  property p_ph_autoclr;
    s_ph_clr_req |=> s_ph_clr_done;
  endproperty
  a_ph_autoclr: assert property (p_ph_autoclr) else $error("phase auto-clear missing");
  property p_f_autoclr;
    s_f_clr_req |=> s_f_clr_done;
  endproperty
  a_f_autoclr: assert property (p_f_autoclr) else $error("frequency auto-clear missing");
  property p_f_static;
    cf_q[ddspr_pkg::BIT_FREQ_CLR] |=> (facc_q == 48'h0);
  endproperty
  a_f_static: assert property (p_f_static) else $error("frequency accumulator not held");
  property p_ph_static;
    cf_q[ddspr_pkg::BIT_PH_CLR] |=> (pacc_q == 48'h0);
  endproperty
  a_ph_static: assert property (p_ph_static) else $error("phase accumulator not held");
  property p_update_copy;
    i_io_update |=> (p6_q == $past(p6b_q)) && (cf_q == $past(cfb_q));
  endproperty
  a_update_copy: assert property (p_update_copy) else $error("update did not copy");
  property p_ramp_reload;
    (i_io_update && cfb_q[ddspr_pkg::BIT_RAMP_RELOAD] && i_sweep_active)
      |=> (ramp_q == $past(i_sweep_ramp_rate));
  endproperty
  a_ramp_reload: assert property (p_ramp_reload) else $error("ramp not restarted");
endmodule : ddspr_regs
`default_nettype wire

/* File: shared/ddspr_pkg.sv */
// constants for the dds profile and control register bank
package ddspr_pkg;
  localparam logic [4:0]  ADDR_CTRL_ONE    = 5'h00;
  localparam logic [4:0]  ADDR_PROF_SIX    = 5'h0c;
  localparam logic [4:0]  ADDR_PROF_SEVEN  = 5'h0d;
  localparam int          INSTR_BITS       = 8;
  localparam int          INSTR_READ_BIT   = 7;
  localparam logic [6:0]  PROF_BITS        = 7'h40;
  localparam logic [6:0]  CTRL_BITS        = 7'h20;
  localparam int          POW_MSB          = 61;
  localparam int          POW_LSB          = 48;
  localparam int          FTW_MSB          = 47;
  localparam logic [63:0] PROF_MASK        = 64'h3fff_ffff_ffff_ffff;
  localparam logic [63:0] PROF_RESET       = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CTRL_MASK        = 32'h00fc_8000;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam int          BIT_UNLOCK       = 24;
  localparam int          BIT_RAMP_RELOAD  = 23;
  localparam int          BIT_FREQ_AUTOCLR = 22;
  localparam int          BIT_PH_AUTOCLR   = 21;
  localparam int          BIT_SINE         = 20;
  localparam int          BIT_FREQ_CLR     = 19;
  localparam int          BIT_PH_CLR       = 18;
  localparam int          BIT_LSB_FIRST    = 15;
  localparam logic [1:0]  SYNC_DIV_LAST    = 2'h3;
  localparam logic [13:0] COS_QUARTER_TURN = 14'h1000;
endpackage : ddspr_pkg

/* File: dv/ddspr_host.sv */
// serial port host model for the dds register bank
`timescale 1ns/1ns
`default_nettype none
module ddspr_host (
  input  wire logic i_clk,
  input  wire logic i_sdio,
  input  wire logic i_sdio_oe,
  output logic      o_sclk,
  output logic      o_csb_n,
  output logic      o_sdio
);
  logic lsb_q;
  initial begin
    lsb_q   = 1'b0; // msb first out of reset
    o_sclk  = 1'b0;
    o_csb_n = 1'b1;
    o_sdio  = 1'b0;
  end
  // whole register each frame, open bits already zero in wd
  task automatic xfer(input logic rd, input logic [4:0] adr, input logic [63:0] wd,
                      input int nb, output logic [63:0] rdat);
    logic [7:0] ins;
    int         j;
    ins  = {rd, 2'h0, adr};
    rdat = '0;
    @(negedge i_clk) o_csb_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      j = lsb_q ? i - 8 : nb + 7 - i;
      @(negedge i_clk) o_sclk = 1'b0;
      if (i < 8) o_sdio = lsb_q ? ins[i] : ins[7 - i];
      else if (rd) o_sdio = ~o_sdio;
      else o_sdio = wd[j];
      repeat (2) @(negedge i_clk);
      if (rd && i >= 8) rdat[j] = i_sdio_oe ? i_sdio : 1'bx;
      o_sclk = 1'b1;
      @(negedge i_clk);
    end
    @(negedge i_clk) o_sclk = 1'b0;
    @(negedge i_clk) o_csb_n = 1'b1;
    @(negedge i_clk);
  endtask : xfer
endmodule : ddspr_host
`default_nettype wire

/* File: dv/ddspr_regs_test.sv */
// self-checking bench for the dds register bank
`timescale 1ns/1ns
`default_nettype none
module ddspr_regs_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        upd = 1'b0;
  logic        unl = 1'b0;
  logic        sim = 1'b0;
  logic        psel = 1'b0;
  logic        swp = 1'b0;
  logic [7:0]  rr = 8'h01;
  logic [47:0] dlt = 48'h0;
  logic [47:0] tw0 = 48'h0;
  logic        sclk, csb_n, sdi, sdo, oe, tick, unlock;
  logic [47:0] fw;
  logic [13:0] pw;
  int          mismatches = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  ddspr_regs ddspr_regs_i (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_sclk(sclk),
    .i_csb_n(csb_n), .i_sdio(sdi), .o_sdio(sdo), .o_sdio_oe(oe), .i_io_update(upd),
    .i_pll_unlock(unl), .i_sync_in_mode(sim), .i_profile_sel(psel), .i_sweep_active(swp),
    .i_sweep_ramp_rate(rr), .i_sweep_delta(dlt), .i_tuning_word_zero(tw0),
    .o_sync_tick(tick), .o_freq_word(fw), .o_phase_word(pw), .o_unlock(unlock));
  ddspr_host ddspr_host_i (.i_clk(clk), .i_sdio(sdo), .i_sdio_oe(oe), .o_sclk(sclk),
    .o_csb_n(csb_n), .o_sdio(sdi));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic update();
    @(negedge clk) upd = 1'b1;
    @(negedge clk) upd = 1'b0;
  endtask : update
  task automatic wr(input logic [4:0] a, input logic [63:0] d, input int nb);
    logic [63:0] r;
    ddspr_host_i.xfer(1'b0, a, d, nb, r);
  endtask : wr
  task automatic rd(input logic [4:0] a, input int nb, output logic [63:0] r);
    ddspr_host_i.xfer(1'b1, a, 64'h0, nb, r);
  endtask : rd
  function automatic logic [13:0] exp_phase(input logic [13:0] off, input logic sine);
    return sine ? off : off + ddspr_pkg::COS_QUARTER_TURN;
  endfunction : exp_phase
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #900000;
    mismatches++;
    end_of_test();
  end
  initial begin
    logic [63:0] r, p6, p7, q;
    logic [31:0] c;
    logic        sf, sp;
    int          n;
    void'($urandom(32'h7d5433c6));
    tw0 = 48'({$urandom, $urandom});
    dlt = 48'({$urandom, $urandom}) | 48'h1;
    p6  = {$urandom, $urandom} & ddspr_pkg::PROF_MASK;
    p7  = ddspr_pkg::PROF_MASK;
    q   = {$urandom, $urandom} & ddspr_pkg::PROF_MASK;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      rd(k == 2 ? ddspr_pkg::ADDR_CTRL_ONE : ddspr_pkg::ADDR_PROF_SIX + 5'(k), k == 2 ? 32 : 64, r);
      check(r, 64'h0);
    end
    n = 0;
    repeat (40) @(negedge clk) n += int'(tick);
    check(64'(n), 64'ha);
    n = 0;
    while (!tick && n < 8) @(negedge clk) n++;
    ce = 1'b0;
    n  = 0;
    repeat (20) @(negedge clk) n += int'(tick);
    ce = 1'b1;
    check(64'(n), 64'h14);
    wr(ddspr_pkg::ADDR_PROF_SIX, p6, 64);
    wr(ddspr_pkg::ADDR_PROF_SEVEN, p7, 64);
    check(64'(fw), 64'h0);
    rd(ddspr_pkg::ADDR_PROF_SIX, 64, r);
    check(r, p6);
    rd(ddspr_pkg::ADDR_PROF_SEVEN, 64, r);
    check(r, p7);
    rd(5'h1f, 8, r);
    check(r, 64'h0000_0000_0000_00xx);
    check(64'(oe), 64'h0);
    for (int s = 0; s < 2; s++) begin
      c = 32'h0;
      c[ddspr_pkg::BIT_FREQ_CLR] = 1'b1;
      c[ddspr_pkg::BIT_PH_CLR]   = 1'b1;
      c[ddspr_pkg::BIT_SINE]     = s[0];
      wr(ddspr_pkg::ADDR_CTRL_ONE, 64'(c), 32);
      update();
      psel = s[0];
      repeat (8) @(negedge clk);
      r = s[0] ? p7 : p6;
      check(64'(fw), 64'(r[47:0]));
      check(64'(pw), 64'(exp_phase(r[61:48], s[0])));
    end
    c = 32'h0;
    c[ddspr_pkg::BIT_FREQ_AUTOCLR] = 1'b1;
    c[ddspr_pkg::BIT_PH_AUTOCLR]   = 1'b1;
    c[ddspr_pkg::BIT_SINE]         = 1'b1;
    wr(ddspr_pkg::ADDR_CTRL_ONE, 64'(c), 32);
    update();
    swp = 1'b1;
    repeat (60) @(negedge clk);
    check(64'(fw !== tw0), 64'h1);
    update();
    sf = 1'b0;
    sp = 1'b0;
    repeat (10) @(negedge clk) begin
      sf |= fw === tw0;
      sp |= pw === p7[61:48];
    end
    check(64'(sf), 64'h1);
    check(64'(sp), 64'h1);
    c = 32'h0;
    c[ddspr_pkg::BIT_RAMP_RELOAD] = 1'b1;
    wr(ddspr_pkg::ADDR_CTRL_ONE, 64'(c), 32);
    rr = 8'h07;
    update();
    repeat (4) @(negedge clk);
    r  = 64'(fw);
    sf = 1'b0;
    repeat (6) begin
      repeat (12) @(negedge clk) sf |= fw !== r[47:0];
      update();
    end
    check(64'(sf), 64'h0);
    swp = 1'b0;
    sim = 1'b1;
    @(negedge clk) unl = 1'b1;
    @(negedge clk) unl = 1'b0;
    repeat (3) @(negedge clk);
    check(64'(unlock), 64'h1);
    rd(ddspr_pkg::ADDR_CTRL_ONE, 32, r);
    check(r, 64'(c | 32'h0100_0000));
    check(64'(unlock), 64'h0);
    sim = 1'b0;
    @(negedge clk) unl = 1'b1;
    @(negedge clk) unl = 1'b0;
    repeat (3) @(negedge clk);
    check(64'(unlock), 64'h0);
    c = 32'h0;
    c[ddspr_pkg::BIT_LSB_FIRST] = 1'b1;
    wr(ddspr_pkg::ADDR_CTRL_ONE, 64'(c), 32);
    update();
    ddspr_host_i.lsb_q = 1'b1;
    wr(ddspr_pkg::ADDR_PROF_SIX, q, 64);
    rd(ddspr_pkg::ADDR_PROF_SIX, 64, r);
    check(r, q);
    rd(ddspr_pkg::ADDR_CTRL_ONE, 32, r);
    check(r, 64'(c));
    wr(ddspr_pkg::ADDR_CTRL_ONE, 64'h0, 32);
    update();
    ddspr_host_i.lsb_q = 1'b0;
    rd(ddspr_pkg::ADDR_CTRL_ONE, 32, r);
    check(r, 64'h0);
    end_of_test();
  end
endmodule : ddspr_regs_test
`default_nettype wire
